// file: design/scpm_pkg.sv
// Behaviour
// R01 - The three-bit clock-select field picks the fast clock or a division of it for codes 000 to 110 and the sub clock for code 111.
// R02 - Code 000 gives the undivided fast clock and codes 001 to 110 give it divided by 2, 4, 8, 16, 32 and 64 in turn.
// R03 - The fast clock comes from the fast RC oscillator and the sub clock from the slow RC oscillator.
// R04 - In FAST mode everything runs and the system clock is the fast oscillator divided by 1 to 64 as the select field says.
// R05 - In SLOW mode the CPU runs on the sub clock, and the slow oscillator and sub clock stay on in both FAST and SLOW modes.
// R06 - On moving from the fast clock to the sub clock the fast oscillator stops or keeps running for peripherals as its enable bit says.
// R07 - There are six modes: FAST and SLOW run the CPU, SLEEP and three idle modes stop it.
// R08 - A halt with both keep bits low enters SLEEP, stopping CPU, system clock, fast clock and peripheral sub clock.
// R09 - In SLEEP the slow oscillator clock runs only while the watchdog is enabled.
// R10 - A halt with only the low keep bit set enters idle_lo_only: CPU and fast clock stop, sub clock runs, system clock runs only on code 111.
// R11 - A halt with both keep bits set enters idle_both_osc: only the CPU stops, every clock runs.
// R12 - A halt with only the high keep bit set enters idle_hi_only: CPU and sub clock stop, fast clock runs, system clock runs only on codes 000 to 110.
// R13 - Setting the fast oscillator enable first clears the stable flag to 0, then sets it to 1 once the oscillator is stable.
// R14 - A switch into SLOW mode does not complete until the slow oscillator is stable.
// R15 - The system clock changes source or division without glitches or runt pulses.
package scpm_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] SCPM_OFS_CLK_CTRL = 8'h00;
  localparam logic [7:0] SCPM_OFS_FOSC_CTRL = 8'h04;
  localparam logic [7:0] SCPM_OFS_STATUS = 8'h08;

  // ==========================================================
  // field positions
  localparam int SCPM_SEL_LSB = 5;
  localparam int SCPM_HI_KEEP_BIT = 1;
  localparam int SCPM_LO_KEEP_BIT = 0;
  localparam int SCPM_FOSC_STABLE_BIT = 1;
  localparam int SCPM_FOSC_EN_BIT = 0;

  // ==========================================================
  // reset values and codes
  localparam logic [2:0] SCPM_SEL_RST = 3'h0;
  localparam logic [2:0] SCPM_SEL_SUB = 3'h7;
  localparam logic SCPM_HI_KEEP_RST = 1'b0;
  localparam logic SCPM_LO_KEEP_RST = 1'b0;
  localparam logic SCPM_FOSC_EN_RST = 1'b1;
  localparam int SCPM_DIV_BITS = 6;
  localparam logic [SCPM_DIV_BITS-1:0] SCPM_DIV_RST = 6'h00;

  // operating modes
  typedef enum logic [2:0] {
    SCPM_FAST,
    SCPM_SLOW,
    SCPM_SLEEP,
    SCPM_IDLE_LO_ONLY,
    SCPM_IDLE_BOTH_OSC,
    SCPM_IDLE_HI_ONLY
  } scpm_mode_e;

endpackage

// file: design/scpm_mux_if.sv
`timescale 1ns/1ps
// ==========================================================
// link between mode control and the system clock switch
interface scpm_mux_if;
  logic [7:0] cand;
  logic [2:0] req_sel;
  logic req_on;
  logic clk_out;
  logic busy;

  modport ctl (
    output cand,
    output req_sel,
    output req_on,
    input clk_out,
    input busy
  );

  modport mux (
    input cand,
    input req_sel,
    input req_on,
    output clk_out,
    output busy
  );
endinterface

// file: design/scpm_clk_switch.sv
`timescale 1ns/1ps
// ==========================================================
// glitch-free selector for the system clock
module scpm_clk_switch (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control side
  scpm_mux_if.mux m
);

  logic [2:0] cur_sel_r;
  logic [2:0] cur_sel_nxt;
  logic cur_on_r;
  logic cur_on_nxt;
  logic pend_r;
  logic pend_nxt;
  logic out_r;
  logic out_nxt;
  logic change;

  assign change = (m.req_sel != cur_sel_r) || (m.req_on != cur_on_r);

  // ==========================================================
  // changeover: park low, then take the new source at its low phase
  always_comb begin
    cur_sel_nxt = cur_sel_r;
    cur_on_nxt = cur_on_r;
    pend_nxt = pend_r;
    if (pend_r) begin
      if (!m.req_on) begin
        pend_nxt = 1'b0;
      end else if (!m.cand[m.req_sel]) begin
        // joining on a low level means the first high is a full one
        cur_sel_nxt = m.req_sel; // [R15]
        cur_on_nxt = 1'b1;
        pend_nxt = 1'b0;
      end
    end else if (change && !out_r) begin
      // only leave the old source while it is low: no cut high pulse
      cur_on_nxt = 1'b0; // [R15]
      pend_nxt = 1'b1;
    end
    out_nxt = cur_on_nxt & m.cand[cur_sel_nxt];
  end

  // switch state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_sel_r <= 3'h0;
      cur_on_r <= 1'b0;
      pend_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      cur_sel_r <= cur_sel_nxt;
      cur_on_r <= cur_on_nxt;
      pend_r <= pend_nxt;
      out_r <= out_nxt;
    end
  end

  assign m.clk_out = out_r;
  assign m.busy = pend_r | change;

endmodule // scpm_clk_switch

// file: design/scpm_top.sv
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// ==========================================================
// system clock selection and power mode control
module scpm_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // cpu side
  input wire logic halt_i,
  input wire logic wake_i,
  input wire logic wdt_en_i,
  output logic cpu_run_o,
  output logic [2:0] mode_o,
  // oscillators, sampled as levels
  input wire logic fast_rc_osc_i,
  input wire logic slow_rc_osc_i,
  input wire logic fast_osc_rdy_i,
  input wire logic slow_osc_rdy_i,
  output logic fast_osc_on_o,
  output logic slow_osc_on_o,
  // clocks to the chip
  output logic sys_clk_o,
  output logic fast_clk_o,
  output logic sub_clk_o,
  output logic slow_osc_clk_o
);

  // ==========================================================
  // software registers
  logic [2:0] sys_clk_sel_r;
  logic hi_osc_halt_keep_r;
  logic lo_osc_halt_keep_r;
  logic fast_osc_en_r;
  logic fast_osc_stable_r;
  logic ack_r;
  logic [31:0] dat_r;

  // mode and clocking state
  scpm_pkg::scpm_mode_e mode_r;
  scpm_pkg::scpm_mode_e mode_nxt;
  logic [2:0] applied_sel_r;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic fast_lvl_d_r;
  logic [scpm_pkg::SCPM_DIV_BITS-1:0] div_r;
  logic fast_on_d_r;
  logic fast_osc_on_r;
  logic slow_osc_on_r;
  logic cpu_run_r;
  logic fast_clk_r;
  logic sub_clk_r;
  logic slow_osc_clk_r;

  // synchronised oscillator levels and ready flags
  logic fast_lvl;
  logic slow_lvl;
  logic fast_rdy;
  logic slow_rdy;

  // gates decided by the mode
  logic fast_gate;
  logic sub_gate;
  logic sys_gate;
  logic slow_osc_gate;
  logic fast_osc_need;

  // bus decode
  logic bus_req;
  logic wr_commit;
  logic wr_lane0;

  scpm_mux_if mux_if ();

  // ==========================================================
  // helpers
  // a select code names a fast-clock division when below 111
  function automatic logic sel_is_fast(input logic [2:0] code);
    sel_is_fast = (code != scpm_pkg::SCPM_SEL_SUB); // [R01]
  endfunction

  // cpu running modes
  function automatic logic mode_runs(input scpm_pkg::scpm_mode_e md);
    mode_runs = (md == scpm_pkg::SCPM_FAST) ||
                (md == scpm_pkg::SCPM_SLOW); // [R07]
  endfunction

  // ==========================================================
  // input synchronisers: oscillators are not on clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {slow_osc_rdy_i, fast_osc_rdy_i, slow_rc_osc_i,
                  fast_rc_osc_i};
      sync2_r <= sync1_r;
    end
  end

  assign fast_lvl = sync2_r[0];
  assign slow_lvl = sync2_r[1];
  assign fast_rdy = sync2_r[2];
  assign slow_rdy = sync2_r[3];

  // ==========================================================
  // fast clock divider, stepping on each rising fast level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_lvl_d_r <= 1'b0;
      div_r <= scpm_pkg::SCPM_DIV_RST;
    end else begin
      fast_lvl_d_r <= fast_lvl;
      if (fast_lvl && !fast_lvl_d_r) begin
        div_r <= div_r + 6'h01; // [R02]
      end
    end
  end

  // candidates: index 0 undivided, index k divides by 2**k, 7 is sub
  always_comb begin
    mux_if.cand[0] = fast_lvl; // [R02] [R03]
    for (int k = 1; k < 7; k++) begin
      mux_if.cand[k] = div_r[k-1]; // [R02]
    end
    mux_if.cand[7] = slow_lvl; // [R03]
  end

  // ==========================================================
  // applied select: a source is only taken once it is stable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      applied_sel_r <= scpm_pkg::SCPM_SEL_RST;
    end else if (sys_clk_sel_r != applied_sel_r) begin
      if (!sel_is_fast(sys_clk_sel_r)) begin
        if (slow_rdy) begin
          applied_sel_r <= sys_clk_sel_r; // [R14]
        end
      end else if (fast_osc_stable_r || sel_is_fast(applied_sel_r)) begin
        // between divisions the fast oscillator is already running
        applied_sel_r <= sys_clk_sel_r; // [R01] [R04]
      end
    end
  end

  // ==========================================================
  // mode sequencing: halt picks the low-power mode from keep bits
  always_comb begin
    mode_nxt = mode_r;
    if (mode_runs(mode_r)) begin
      if (halt_i) begin
        unique case ({hi_osc_halt_keep_r, lo_osc_halt_keep_r})
          2'b00: mode_nxt = scpm_pkg::SCPM_SLEEP; // [R08]
          2'b01: mode_nxt = scpm_pkg::SCPM_IDLE_LO_ONLY; // [R10]
          2'b11: mode_nxt = scpm_pkg::SCPM_IDLE_BOTH_OSC; // [R11]
          2'b10: mode_nxt = scpm_pkg::SCPM_IDLE_HI_ONLY; // [R12]
        endcase
      end else if (sel_is_fast(applied_sel_r)) begin
        mode_nxt = scpm_pkg::SCPM_FAST; // [R04]
      end else begin
        mode_nxt = scpm_pkg::SCPM_SLOW; // [R05]
      end
    end else if (wake_i) begin
      // wake sources live outside; return to the selected run mode
      mode_nxt = sel_is_fast(applied_sel_r) ? scpm_pkg::SCPM_FAST :
                 scpm_pkg::SCPM_SLOW; // [R07]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= scpm_pkg::SCPM_FAST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ==========================================================
  // per-mode clock gates
  always_comb begin
    fast_gate = 1'b0;
    sub_gate = 1'b0;
    sys_gate = 1'b0;
    slow_osc_gate = 1'b1;
    unique case (mode_r)
      scpm_pkg::SCPM_FAST: begin
        fast_gate = 1'b1; // [R04]
        sub_gate = 1'b1; // [R05]
        sys_gate = 1'b1;
      end
      scpm_pkg::SCPM_SLOW: begin
        // fast oscillator kept only for peripherals if enabled
        fast_gate = fast_osc_en_r; // [R06]
        sub_gate = 1'b1; // [R05]
        sys_gate = 1'b1;
      end
      scpm_pkg::SCPM_SLEEP: begin
        slow_osc_gate = wdt_en_i; // [R08] [R09]
      end
      scpm_pkg::SCPM_IDLE_LO_ONLY: begin
        sub_gate = 1'b1; // [R10]
        sys_gate = !sel_is_fast(applied_sel_r); // [R10]
      end
      scpm_pkg::SCPM_IDLE_BOTH_OSC: begin
        fast_gate = 1'b1; // [R11]
        sub_gate = 1'b1;
        sys_gate = 1'b1;
      end
      scpm_pkg::SCPM_IDLE_HI_ONLY: begin
        fast_gate = 1'b1; // [R12]
        sys_gate = sel_is_fast(applied_sel_r); // [R12]
      end
    endcase
  end

  // fast oscillator must also run while a fast code waits to apply
  assign fast_osc_need = fast_gate || sel_is_fast(sys_clk_sel_r) ||
                         (mode_r == scpm_pkg::SCPM_FAST);

  // ==========================================================
  // system clock goes through the glitch-free switch
  assign mux_if.req_sel = applied_sel_r;
  assign mux_if.req_on = sys_gate;

  scpm_clk_switch u_switch (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .m (mux_if.mux)
  );

  // ==========================================================
  // peripheral clocks and oscillator enables, all from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_clk_r <= 1'b0;
      sub_clk_r <= 1'b0;
      slow_osc_clk_r <= 1'b0;
      fast_osc_on_r <= 1'b0;
      slow_osc_on_r <= 1'b0;
      cpu_run_r <= 1'b0;
    end else begin
      fast_clk_r <= fast_gate & fast_lvl; // [R03]
      sub_clk_r <= sub_gate & slow_lvl; // [R03]
      slow_osc_clk_r <= slow_osc_gate & slow_lvl; // [R09]
      fast_osc_on_r <= fast_osc_need; // [R06]
      slow_osc_on_r <= slow_osc_gate; // [R05] [R09]
      cpu_run_r <= mode_runs(mode_nxt); // [R07]
    end
  end

  // ==========================================================
  // fast oscillator stable flag
  // a fresh enable drops the flag first, so stale ready is not trusted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_on_d_r <= 1'b0;
      fast_osc_stable_r <= 1'b0;
    end else begin
      fast_on_d_r <= fast_osc_on_r;
      if (!fast_osc_on_r || !fast_on_d_r) begin
        fast_osc_stable_r <= 1'b0; // [R13]
      end else if (fast_rdy) begin
        fast_osc_stable_r <= 1'b1; // [R13]
      end
    end
  end

  // ==========================================================
  // wishbone slave: ack one cycle after the strobe, data with it
  assign bus_req = cyc_i && stb_i;
  assign wr_commit = bus_req && we_i && ack_r;
  assign wr_lane0 = wr_commit && sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req && !ack_r;
    end
  end

  // register writes land on the acked edge; upper lanes hold nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_clk_sel_r <= scpm_pkg::SCPM_SEL_RST;
      hi_osc_halt_keep_r <= scpm_pkg::SCPM_HI_KEEP_RST;
      lo_osc_halt_keep_r <= scpm_pkg::SCPM_LO_KEEP_RST;
      fast_osc_en_r <= scpm_pkg::SCPM_FOSC_EN_RST;
    end else if (wr_lane0) begin
      if (adr_i == scpm_pkg::SCPM_OFS_CLK_CTRL) begin
        sys_clk_sel_r <= dat_i[scpm_pkg::SCPM_SEL_LSB +: 3]; // [R01]
        hi_osc_halt_keep_r <= dat_i[scpm_pkg::SCPM_HI_KEEP_BIT];
        lo_osc_halt_keep_r <= dat_i[scpm_pkg::SCPM_LO_KEEP_BIT];
      end
      if (adr_i == scpm_pkg::SCPM_OFS_FOSC_CTRL) begin
        fast_osc_en_r <= dat_i[scpm_pkg::SCPM_FOSC_EN_BIT]; // [R06]
      end
    end
  end

  // read data captured with ack; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (bus_req && !ack_r) begin
      dat_r <= 32'h0000_0000;
      unique case (adr_i)
        scpm_pkg::SCPM_OFS_CLK_CTRL: begin
          dat_r[scpm_pkg::SCPM_SEL_LSB +: 3] <= sys_clk_sel_r;
          dat_r[scpm_pkg::SCPM_HI_KEEP_BIT] <= hi_osc_halt_keep_r;
          dat_r[scpm_pkg::SCPM_LO_KEEP_BIT] <= lo_osc_halt_keep_r;
        end
        scpm_pkg::SCPM_OFS_FOSC_CTRL: begin
          dat_r[scpm_pkg::SCPM_FOSC_STABLE_BIT] <= fast_osc_stable_r;
          dat_r[scpm_pkg::SCPM_FOSC_EN_BIT] <= fast_osc_en_r;
        end
        scpm_pkg::SCPM_OFS_STATUS: begin
          dat_r[2:0] <= mode_r;
          dat_r[3] <= mux_if.busy;
          dat_r[4] <= slow_rdy;
          dat_r[7:5] <= applied_sel_r;
        end
        default: begin
          dat_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign cpu_run_o = cpu_run_r;
  assign mode_o = mode_r;
  assign fast_osc_on_o = fast_osc_on_r;
  assign slow_osc_on_o = slow_osc_on_r;
  assign sys_clk_o = mux_if.clk_out;
  assign fast_clk_o = fast_clk_r;
  assign sub_clk_o = sub_clk_r;
  assign slow_osc_clk_o = slow_osc_clk_r;

endmodule // scpm_top

// file: sim/scpm_top_sva.sv
`timescale 1ns/1ps
// ==========================================================
// port-level checks on the clock and mode block
module scpm_top_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // cpu side and clocks
  input wire logic halt_i,
  input wire logic wdt_en_i,
  input wire logic cpu_run_o,
  input wire logic [2:0] mode_o,
  input wire logic fast_osc_on_o,
  input wire logic fast_clk_o,
  input wire logic sub_clk_o,
  input wire logic slow_osc_clk_o
);
  logic [1:0] keep_r;
  logic ctrl_wr;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // keep bits shadowed so halt entries can be predicted
  assign ctrl_wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keep_r <= 2'h0;
    end else if (ctrl_wr && adr_i == 8'h00) begin
      keep_r <= dat_i[1:0];
    end
  end
  // bus answer: one cycle after the take, one cycle long
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  // halt entry picks the mode from the keep bits
  AST_HALT_STOP: assert property (halt_i && cpu_run_o |=> !cpu_run_o)
    else $error("cpu still running after halt");
  AST_SLEEP_IN: assert property (halt_i && cpu_run_o && keep_r == 2'h0
    |=> mode_o == 3'h2) else $error("halt did not enter sleep");
  AST_LO_IN: assert property (halt_i && cpu_run_o && keep_r == 2'h1
    |=> mode_o == 3'h3) else $error("halt did not enter idle lo");
  AST_BOTH_IN: assert property (halt_i && cpu_run_o && keep_r == 2'h3
    |=> mode_o == 3'h4) else $error("halt did not enter idle both");
  AST_HI_IN: assert property (halt_i && cpu_run_o && keep_r == 2'h2
    |=> mode_o == 3'h5) else $error("halt did not enter idle hi");
  // clock gating once the 1-cycle output lag has passed
  AST_SLEEP_GATE: assert property ((mode_o == 3'h2) [*8]
    |-> !fast_clk_o && !sub_clk_o) else $error("clock runs in sleep");
  AST_WDT_GATE: assert property ((mode_o == 3'h2 && !wdt_en_i) [*8]
    |-> !slow_osc_clk_o) else $error("slow clock runs without wdt");
  AST_LO_GATE: assert property ((mode_o == 3'h3) [*8]
    |-> !fast_clk_o) else $error("fast clock runs in idle lo");
  AST_HI_GATE: assert property ((mode_o == 3'h5) [*8]
    |-> !sub_clk_o) else $error("sub clock runs in idle hi");
  AST_FAST_ON: assert property (cpu_run_o && mode_o == 3'h0
    |-> fast_osc_on_o) else $error("fast oscillator off in fast mode");
endmodule // scpm_top_sva

bind scpm_top scpm_top_sva scpm_top_sva_i (.clk_i, .rst_i, .adr_i, .dat_i,
  .sel_i, .we_i, .cyc_i, .stb_i, .ack_o, .halt_i, .wdt_en_i, .cpu_run_o,
  .mode_o, .fast_osc_on_o, .fast_clk_o, .sub_clk_o, .slow_osc_clk_o);

// file: sim/testbench.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the clock and mode block
module testbench;
  typedef struct {logic [31:0] v; logic [31:0] m; string n;} scpm_exp_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic halt_i = 1'b0, wake_i = 1'b0, wdt_en_i = 1'b0;
  logic fast_rc_osc_i = 1'b0, slow_rc_osc_i = 1'b0;
  logic fast_osc_rdy_i = 1'b1, slow_osc_rdy_i = 1'b1;
  logic [31:0] dat_o, rd;
  logic [31:0] lfsr = 32'h8be8;
  logic [2:0] mode_o;
  logic [3:0] ph = 4'h0;
  logic hi;
  logic ack_o, cpu_run_o, fast_osc_on_o, slow_osc_on_o;
  logic sys_clk_o, fast_clk_o, sub_clk_o, slow_osc_clk_o;
  logic [2:0] mexp [4] = '{3'h2, 3'h3, 3'h5, 3'h4};
  int failures = 0;
  int cmp_count = 0;
  int p;
  scpm_exp_s expq[$];
  scpm_exp_s e;

  scpm_top scpm_top_i (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .sel_i,
    .we_i, .cyc_i, .stb_i, .ack_o, .halt_i, .wake_i, .wdt_en_i, .cpu_run_o,
    .mode_o, .fast_rc_osc_i, .slow_rc_osc_i, .fast_osc_rdy_i,
    .slow_osc_rdy_i, .fast_osc_on_o, .slow_osc_on_o, .sys_clk_o,
    .fast_clk_o, .sub_clk_o, .slow_osc_clk_o);

  // ==========================================================
  // clock and fast and slow oscillator stand-ins (periods 4 and 16 cycles)
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ph <= ph + 4'h1;
    if (ph[0]) fast_rc_osc_i <= ~fast_rc_osc_i;
    if (ph[2:0] == 3'h7) slow_rc_osc_i <= ~slow_rc_osc_i;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask
  // classic cycle: hold until ack is sampled, release at that edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  // read with a noted expectation; mask 0 means not compared
  task automatic rdx(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] v, input string n);
    expq.push_back(scpm_exp_s'{v, m, n});
    wb(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    int i;
    for (i = 0; i < 300; i++) begin
      rdx(a, 32'h0, 32'h0, "poll");
      if ((rd & m) === v) break;
    end
    if (i == 300) begin
      failures++;
      $display("BAD poll %h expected %h seen %h", a, v, rd & m);
    end
  endtask
  // cycles between two sampled rising edges of the system clock
  task automatic per(output int n);
    n = 0;
    while (sys_clk_o !== 1'b0) @(posedge clk_i);
    while (sys_clk_o !== 1'b1) @(posedge clk_i);
    do begin
      @(posedge clk_i);
      n++;
    end while (sys_clk_o !== 1'b0);
    while (sys_clk_o !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // monitor: oldest note against each read answer
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && cyc_i && !we_i && expq.size() > 0) begin
      e = expq.pop_front();
      if (e.m != 32'h0) check(e.n, dat_o & e.m, e.v);
    end
  end

  // watchdog: whole run needs well under 20000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    $display("BAD watchdog expected finish seen hang");
    summarize;
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rdx(8'h00, 32'hffffffff, 32'h0, "ctrl_rst");
    rdx(8'h04, 32'h1, 32'h1, "fosc_en_rst");
    wb(1'b1, 8'h00, 32'he0, 4'he);
    rdx(8'h00, 32'hffffffff, 32'h0, "ctrl_nosel");
    rdx(8'h0c, 32'hffffffff, 32'h0, "unmapped");
    $display("test reset and refusals done");
    // every fast code, reserved bits random and reading back 0
    for (int c = 0; c < 7; c++) begin
      lfsr = nxt(lfsr);
      wb(1'b1, 8'h00, {24'h0, c[2:0], lfsr[2:0], 2'h0}, 4'h1);
      rdx(8'h00, 32'hff, {24'h0, c[2:0], 5'h0}, "ctrl_sel");
      poll(8'h08, 32'he0, {24'h0, c[2:0], 5'h0});
      per(p);
      per(p);
      check("sys_period", 32'(p), 32'(4 << c));
    end
    $display("test division codes done");
    // slow switch waits for a ready slow oscillator
    slow_osc_rdy_i <= 1'b0;
    wb(1'b1, 8'h00, 32'he0, 4'h1);
    repeat (40) @(posedge clk_i);
    rdx(8'h08, 32'hff, 32'hc0, "held_switch");
    slow_osc_rdy_i <= 1'b1;
    poll(8'h08, 32'he0, 32'he0);
    rdx(8'h08, 32'hf7, 32'hf1, "slow_mode");
    per(p);
    per(p);
    check("sub_period", 32'(p), 32'd16);
    // fast oscillator follows its enable only in slow mode
    wb(1'b1, 8'h04, 32'h0, 4'h1);
    repeat (8) @(posedge clk_i);
    rdx(8'h04, 32'h3, 32'h0, "fosc_off");
    check("fosc_pin", {31'h0, fast_osc_on_o}, 32'h0);
    wb(1'b1, 8'h04, 32'h1, 4'h1);
    poll(8'h04, 32'h2, 32'h2);
    rdx(8'h04, 32'h3, 32'h3, "fosc_stable");
    $display("test slow mode done");
    // halt with each keep pair; second halt while halted is refused
    wb(1'b1, 8'h00, 32'h0, 4'h1);
    poll(8'h08, 32'he0, 32'h0);
    for (int k = 0; k < 4; k++) begin
      lfsr = nxt(lfsr);
      wb(1'b1, 8'h00, {30'h0, k[1:0]}, 4'h1);
      wdt_en_i <= (k == 0) ? 1'b0 : lfsr[0];
      @(posedge clk_i);
      halt_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      halt_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      rdx(8'h08, 32'h7, {29'h0, mexp[k]}, "halt_mode");
      check("cpu_run", {31'h0, cpu_run_o}, 32'h0);
      check("slow_osc_on", {31'h0, slow_osc_on_o}, {31'h0, (k != 0)});
      // select is undivided fast: high seen in 8 cycles if it runs
      hi = 1'b0;
      repeat (8) begin
        @(posedge clk_i);
        hi = hi | sys_clk_o;
      end
      check("sys_run", {31'h0, hi}, {31'h0, k[1]});
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rdx(8'h08, 32'h7, 32'h0, "wake_mode");
    end
    $display("test halt modes done");
    summarize;
  end
endmodule // testbench
